// >>> inc/ptp_pkg.sv
// Purpose: shared constants of the power and thermal protection supervisor
// Assumes: 100 MHz clock, one millisecond housekeeping tick
// Notes:   fault bit positions index the sticky fault vector of the top

package ptp_pkg;

   // clock and housekeeping tick
   localparam int CLK_NS        = 10;
   localparam int TICK_NS       = 1000000;                     // one millisecond
   localparam int TICK_CYC      = (TICK_NS + CLK_NS - 1) / CLK_NS;

   // charge gauge timing, rate unit is 0.1 s per percent
   localparam int GAUGE_DEF_MS  = 16800;                       // 16.8 s per percent
   localparam int GAUGE_STEP_MS = 100;
   localparam logic [6:0] GAUGE_FULL = 7'h64;                  // 100 percent
   localparam logic [6:0] GAUGE_ZERO = 7'h00;

   // fan stall window
   localparam int STALL_MS      = 1000;

   // cutback scale, full effort
   localparam logic [7:0] SCALE_FULL = 8'hff;

   // motor temperature estimate leak per tick, as a right shift
   localparam int EST_LEAK_SH   = 8;

   // sticky fault vector layout
   localparam int FLT_W         = 5;
   localparam int FLT_STALL     = 0;
   localparam int FLT_MOT_OT    = 1;
   localparam int FLT_OVSPD     = 2;
   localparam int FLT_OV        = 3;
   localparam int FLT_UV        = 4;

   // under-voltage cut-out sequence
   typedef enum logic [1:0] {
      PTP_UV_OK   = 2'b00,
      PTP_UV_WAIT = 2'b01,
      PTP_UV_TRIP = 2'b10
   } ptp_uv_t;

endpackage

// >>> hdl/ptp_sync.sv
// Purpose: two-flop synchroniser for asynchronous pin levels
// Assumes: inputs are slow levels, no pulse narrower than two clocks
// Notes:   only the second stage leaves the module

`timescale 1ns/10ps

module ptp_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         sys_rst,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } ptp_sync_st_t;

   ptp_sync_st_t st;
   ptp_sync_st_t next_st;

   // first stage feeds only the second
   always_comb begin
      next_st    = st;
      next_st.s1 = din;
      next_st.s2 = st.s1;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign dout = st.s2;

endmodule

// >>> hdl/ptp_hyst.sv
// Purpose: on/off threshold comparator with hysteresis for one fan
// Assumes: on threshold programmed above off threshold
// Notes:   inverted thresholds give on-priority, never oscillation per cycle

`timescale 1ns/10ps

module ptp_hyst #(
   parameter int TW = 12
) (
   input  wire logic          clk,
   input  wire logic          sys_rst,
   input  wire logic [TW-1:0] temp,
   input  wire logic [TW-1:0] on_t,
   input  wire logic [TW-1:0] off_t,
   output logic               on
);

   typedef struct packed {
      logic on;
   } ptp_hyst_st_t;

   ptp_hyst_st_t st;
   ptp_hyst_st_t next_st;

   always_comb begin
      next_st = st;
      if (temp > on_t) begin
         next_st.on = 1'b1;
      end else if (temp <= off_t) begin
         next_st.on = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign on = st.on;

endmodule

// >>> hdl/ptp_top.sv
// Purpose: fan control, motor and battery protection, charge gauge
// Assumes: measured values arrive synchronous to clk; pins are synchronised here
// Notes:   all configuration is plain ports; faults are sticky until fault_clr
//
// Contract
// - motor fan output only while seat switch shows operator present.
// - heatsink fans turn on above the switch-on temperature.
// - heatsink fans turn off at or below the switch-off temperature.
// - when enabled, stopped heatsink fans raise a warning fault.
// - external fan on above threshold of selected source, at fan voltage.
// - external fan off once chosen source falls to switch-off temperature.
// - external fan not driven on an output used by another function.
// - current-based motor temperature estimate always applied beside direct inputs.
// - brake above speed limit; trip speed exceeded shuts down with fault.
// - above over-voltage start, braking effort reduced linearly.
// - voltage above over-voltage cut-out level cuts out with fault.
// - below under-voltage start, battery current drawn reduced linearly.
// - under-voltage cut-out only after staying low past protection delay.
// - cell count zero disables the charge gauge entirely.
// - per-cell voltage at reset level sets the gauge to 100 percent.
// - gauge at cut-out level selects the low-battery profile.
// - gauge drops one percent per rate interval; rate zero means 16.8 s.
// - warning and cut-out levels of zero percent disable those actions.
// - charge and discharge current limited apart; discharge limit per profile.
// - regenerative current reported as negative values.

`timescale 1ns/10ps

module ptp_top #(
   parameter int TW       = 12,
   parameter int VW       = 16,
   parameter int SW       = 16,
   parameter int IW       = 16,
   parameter int NOUT     = 8,
   parameter int TICK_CYC = ptp_pkg::TICK_CYC
) (
   input  wire logic                    clk,
   input  wire logic                    sys_rst,
   input  wire logic                    seat_sw,
   input  wire logic                    fan_tach,
   input  wire logic                    mot_ot_sw,
   input  wire logic [TW-1:0]           hs_temp,
   input  wire logic [TW-1:0]           mot_temp,
   input  wire logic [VW-1:0]           batt_v,
   input  wire logic [SW-1:0]           mot_speed,
   input  wire logic signed [IW-1:0]    mot_curr,
   input  wire logic signed [IW-1:0]    batt_curr,
   input  wire logic                    mfan_en,
   input  wire logic [TW-1:0]           hs_on_t,
   input  wire logic [TW-1:0]           hs_off_t,
   input  wire logic                    stall_en,
   input  wire logic [TW-1:0]           xf_on_t,
   input  wire logic [TW-1:0]           xf_off_t,
   input  wire logic                    xf_src_mot,
   input  wire logic [2:0]              xf_out_sel,
   input  wire logic [7:0]              xf_volt,
   input  wire logic [NOUT-1:0]         out_busy,
   input  wire logic [3:0]              est_gain,
   input  wire logic [23:0]             est_limit,
   input  wire logic [TW-1:0]           mot_t_limit,
   input  wire logic [SW-1:0]           speed_lim,
   input  wire logic [SW-1:0]           trip_speed,
   input  wire logic [VW-1:0]           ov_start,
   input  wire logic [VW-1:0]           ov_cut,
   input  wire logic [2:0]              ov_gain,
   input  wire logic [VW-1:0]           uv_start,
   input  wire logic [VW-1:0]           uv_cut,
   input  wire logic [2:0]              uv_gain,
   input  wire logic [15:0]             uv_delay_ms,
   input  wire logic [7:0]              cells,
   input  wire logic [15:0]             reset_cell_v,
   input  wire logic [9:0]              gauge_rate,
   input  wire logic [6:0]              warn_pct,
   input  wire logic [6:0]              cut_pct,
   input  wire logic [IW-1:0]           chg_lim,
   input  wire logic [IW-1:0]           dis_lim [4],
   input  wire logic [1:0]              profile,
   input  wire logic                    fault_clr,
   output logic                         mfan_out,
   output logic                         hs_fan_out,
   output logic [NOUT-1:0]              xf_out,
   output logic [7:0]                   xf_level,
   output logic                         brake_req,
   output logic [7:0]                   brake_scale,
   output logic [7:0]                   drive_scale,
   output logic                         cutout,
   output logic [ptp_pkg::FLT_W-1:0]    faults,
   output logic [6:0]                   gauge_pct,
   output logic                         gauge_warn,
   output logic                         low_batt_prof,
   output logic signed [IW-1:0]         dis_lim_act,
   output logic signed [IW-1:0]         chg_lim_act,
   output logic                         curr_cut_dis,
   output logic                         curr_cut_chg,
   output logic signed [IW-1:0]         batt_curr_rpt
);

   typedef struct packed {
      logic [16:0]              pre;
      logic                     tick;
      logic                     tach_d;
      logic [10:0]              stall_ms;
      logic [23:0]              est;
      ptp_pkg::ptp_uv_t         uv;
      logic [15:0]              uv_ms;
      logic [16:0]              g_ms;
      logic                     mfan;
      logic                     hsf;
      logic [NOUT-1:0]          xf;
      logic [7:0]               xlev;
      logic                     brk;
      logic [7:0]               bscale;
      logic [7:0]               dscale;
      logic [ptp_pkg::FLT_W-1:0] flt;
      logic                     cut;
      logic [6:0]               gauge;
      logic                     gwarn;
      logic                     lowb;
      logic signed [IW-1:0]     dlim;
      logic signed [IW-1:0]     clim;
      logic                     cdis;
      logic                     cchg;
      logic signed [IW-1:0]     icur;
   } ptp_st_t;

   ptp_st_t st;
   ptp_st_t next_st;

   logic [2:0]    pin_s;
   logic          hs_on;
   logic          xf_on;
   logic [TW-1:0] xf_temp;

   // seat, tach and thermal switch come straight from pins
   ptp_sync #(
      .W    (3)
   ) u_sync (
      .clk     (clk),
      .sys_rst (sys_rst),
      .din     ({mot_ot_sw, fan_tach, seat_sw}),
      .dout    (pin_s)
   );

   // internal heatsink fans
   ptp_hyst #(
      .TW   (TW)
   ) u_hs_hyst (
      .clk     (clk),
      .sys_rst (sys_rst),
      .temp    (hs_temp),
      .on_t    (hs_on_t),
      .off_t   (hs_off_t),
      .on      (hs_on)
   );

   assign xf_temp = xf_src_mot ? mot_temp : hs_temp;

   ptp_hyst #(
      .TW   (TW)
   ) u_xf_hyst (
      .clk     (clk),
      .sys_rst (sys_rst),
      .temp    (xf_temp),
      .on_t    (xf_on_t),
      .off_t   (xf_off_t),
      .on      (xf_on)
   );

   // scratch terms of the next-state logic
   logic [IW-1:0] i_abs;
   logic [24:0]   est_sum;
   logic [23:0]   red;
   logic [23:0]   g_ref;
   logic [16:0]   g_int;
   logic [6:0]    g_new;
   logic [ptp_pkg::FLT_W-1:0] fset;

   always_comb begin
      next_st  = st;
      fset     = '0;
      i_abs    = '0;
      est_sum  = '0;
      red      = '0;
      g_ref    = '0;
      g_int    = '0;
      g_new    = st.gauge;

      // millisecond housekeeping tick
      next_st.tick = 1'b0;
      if (st.pre == 17'(TICK_CYC - 1)) begin
         next_st.pre  = '0;
         next_st.tick = 1'b1;
      end else begin
         next_st.pre = st.pre + 17'h00001;
      end

      next_st.mfan = mfan_en & pin_s[0];

      next_st.hsf = hs_on;

      next_st.tach_d = pin_s[1];
      if (!st.hsf || (pin_s[1] != st.tach_d)) begin
         next_st.stall_ms = '0;
      end else if (st.tick && st.stall_ms != 11'(ptp_pkg::STALL_MS)) begin
         next_st.stall_ms = st.stall_ms + 11'h001;
      end
      fset[ptp_pkg::FLT_STALL] = stall_en && (st.stall_ms == 11'(ptp_pkg::STALL_MS));

      next_st.xf   = '0;
      next_st.xlev = 8'h00;
      if (xf_on && !out_busy[xf_out_sel]) begin
         next_st.xf[xf_out_sel] = 1'b1;
         next_st.xlev           = xf_volt;
      end

      i_abs = mot_curr[IW-1] ? IW'(-mot_curr) : IW'(mot_curr);
      if (st.tick) begin
         est_sum = {1'b0, st.est} - 25'({1'b0, st.est} >> ptp_pkg::EST_LEAK_SH)
                   + (25'(i_abs) << est_gain);
         next_st.est = est_sum[24] ? 24'hffffff : est_sum[23:0];
      end
      fset[ptp_pkg::FLT_MOT_OT] = (st.est > est_limit) || (mot_temp > mot_t_limit)
                                  || pin_s[2];

      next_st.brk = mot_speed > speed_lim;
      fset[ptp_pkg::FLT_OVSPD] = mot_speed > trip_speed;

      next_st.bscale = ptp_pkg::SCALE_FULL;
      if (batt_v > ov_start) begin
         red = 24'(batt_v - ov_start) << ov_gain;
         next_st.bscale = (red > 24'(ptp_pkg::SCALE_FULL)) ? 8'h00
                          : ptp_pkg::SCALE_FULL - red[7:0];
      end
      fset[ptp_pkg::FLT_OV] = batt_v > ov_cut;

      next_st.dscale = ptp_pkg::SCALE_FULL;
      if (batt_v < uv_start) begin
         red = 24'(uv_start - batt_v) << uv_gain;
         next_st.dscale = (red > 24'(ptp_pkg::SCALE_FULL)) ? 8'h00
                          : ptp_pkg::SCALE_FULL - red[7:0];
      end

      case (st.uv)
         ptp_pkg::PTP_UV_OK: begin
            next_st.uv_ms = '0;
            if (batt_v < uv_cut) begin
               next_st.uv = ptp_pkg::PTP_UV_WAIT;
            end
         end
         ptp_pkg::PTP_UV_WAIT: begin
            if (batt_v >= uv_cut) begin
               next_st.uv = ptp_pkg::PTP_UV_OK;
            end else if (st.uv_ms > uv_delay_ms) begin
               next_st.uv = ptp_pkg::PTP_UV_TRIP;
            end else if (st.tick && st.uv_ms != 16'hffff) begin
               next_st.uv_ms = st.uv_ms + 16'h0001;
            end
         end
         ptp_pkg::PTP_UV_TRIP: begin
            fset[ptp_pkg::FLT_UV] = 1'b1;
            if (batt_v >= uv_cut) begin
               next_st.uv = ptp_pkg::PTP_UV_OK;
            end
         end
         default: begin
            next_st.uv = ptp_pkg::PTP_UV_OK;
         end
      endcase

      // sticky faults, a new event wins over the clear
      next_st.flt = (fault_clr ? '0 : st.flt) | fset;
      // cut-out bit, same edge as the faults
      next_st.cut = next_st.flt[ptp_pkg::FLT_OVSPD] | next_st.flt[ptp_pkg::FLT_OV]
                    | next_st.flt[ptp_pkg::FLT_UV];

      next_st.brk = next_st.brk & ~st.flt[ptp_pkg::FLT_OVSPD];

      g_int = (gauge_rate == 10'h000) ? 17'(ptp_pkg::GAUGE_DEF_MS)
              : 17'(gauge_rate) * 17'(ptp_pkg::GAUGE_STEP_MS);
      g_ref = 24'(cells) * 24'(reset_cell_v);

      if (cells == 8'h00) begin
         g_new         = ptp_pkg::GAUGE_ZERO;
         next_st.g_ms  = '0;
      end else if (24'(batt_v) >= g_ref) begin
         g_new         = ptp_pkg::GAUGE_FULL;
         next_st.g_ms  = '0;
      end else if (st.tick) begin
         if (st.g_ms + 17'h00001 >= g_int) begin
            next_st.g_ms = '0;
            if (st.gauge != ptp_pkg::GAUGE_ZERO) begin
               g_new = st.gauge - 7'h01;
            end
         end else begin
            next_st.g_ms = st.g_ms + 17'h00001;
         end
      end
      next_st.gauge = g_new;

      next_st.gwarn = (cells != 8'h00) && (warn_pct != 7'h00) && (g_new <= warn_pct);
      next_st.lowb  = (cells != 8'h00) && (cut_pct != 7'h00) && (g_new <= cut_pct);

      next_st.dlim = IW'(dis_lim[profile]);
      next_st.clim = IW'(-$signed(chg_lim));
      next_st.cdis = batt_curr > $signed(dis_lim[profile]);
      next_st.cchg = batt_curr < next_st.clim;
      next_st.icur = batt_curr;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // every output comes straight from the state register
   assign mfan_out      = st.mfan;
   assign hs_fan_out    = st.hsf;
   assign xf_out        = st.xf;
   assign xf_level      = st.xlev;
   assign brake_req     = st.brk;
   assign brake_scale   = st.bscale;
   assign drive_scale   = st.dscale;
   assign faults        = st.flt;
   assign gauge_pct     = st.gauge;
   assign gauge_warn    = st.gwarn;
   assign low_batt_prof = st.lowb;
   assign dis_lim_act   = st.dlim;
   assign chg_lim_act   = st.clim;
   assign curr_cut_dis  = st.cdis;
   assign curr_cut_chg  = st.cchg;
   assign batt_curr_rpt = st.icur;

   // cut-out has its own state bit, so no logic sits after the flop
   assign cutout        = st.cut;

endmodule

// >>> tb/ptp_top_assertions.sv
// Purpose: port checks on the protection supervisor
// Assumes: bound into ptp_top, single clock
// Notes:   one-edge relations wait two edges after reset release
`timescale 1ns/10ps
module ptp_top_assertions #(
   parameter int VW = 16,
   parameter int SW = 16,
   parameter int IW = 16
) (
   input wire logic                 clk,
   input wire logic                 sys_rst,
   input wire logic                 seat_sw,
   input wire logic [VW-1:0]        batt_v,
   input wire logic [VW-1:0]        ov_cut,
   input wire logic [SW-1:0]        mot_speed,
   input wire logic [SW-1:0]        speed_lim,
   input wire logic [7:0]           cells,
   input wire logic [IW-1:0]        chg_lim,
   input wire logic signed [IW-1:0] batt_curr,
   input wire logic                 fault_clr,
   input wire logic                 mfan_out,
   input wire logic [7:0]           xf_out,
   input wire logic [7:0]           xf_level,
   input wire logic                 brake_req,
   input wire logic                 cutout,
   input wire logic [4:0]           faults,
   input wire logic [6:0]           gauge_pct,
   input wire logic signed [IW-1:0] chg_lim_act,
   input wire logic signed [IW-1:0] batt_curr_rpt
);
   logic [1:0] rst_q;
   // reset history, outputs settle two edges after release
   always_ff @(posedge clk) rst_q <= {rst_q[0], sys_rst};
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   seat_gate_a: assert property (mfan_out |-> $past(seat_sw, 3))
      else $error("motor fan on without seat");
   ov_trip_a: assert property (rst_q == 2'b00 && batt_v > ov_cut |=> faults[3])
      else $error("over-voltage not tripped");
   ov_sticky_a: assert property (faults[3] && !fault_clr |=> faults[3])
      else $error("over-voltage fault dropped");
   cut_sum_a: assert property (cutout == (faults[2] | faults[3] | faults[4]))
      else $error("cutout does not follow faults");
   brake_stop_a: assert property ($past(faults[2]) |-> !brake_req)
      else $error("brake while tripped");
   brake_cause_a: assert property (brake_req |-> $past(mot_speed > speed_lim))
      else $error("brake without overspeed");
   gauge_off_a: assert property (rst_q == 2'b00 && $past(cells) == 8'h00 |-> gauge_pct == 7'h00)
      else $error("gauge active with no cells");
   gauge_step_a: assert property (rst_q == 2'b00 && $past(cells) != 8'h00
      && gauge_pct != $past(gauge_pct) && gauge_pct != 7'h64
      |-> gauge_pct == $past(gauge_pct) - 7'h01) else $error("gauge step not one");
   xf_level_a: assert property (xf_out == 8'h00 |-> xf_level == 8'h00 ##1 $onehot0(xf_out))
      else $error("fan level without output");
   regen_rpt_a: assert property (rst_q == 2'b00 |-> batt_curr_rpt == $past(batt_curr)
      && chg_lim_act == -$signed($past(chg_lim))) else $error("current report wrong");
endmodule

// >>> tb/ptp_fan_model.sv
// Purpose: heatsink fan with tach, can be jammed
// Assumes: tach level toggles while rotor spins
// Notes:   a jammed rotor holds its last tach level
`timescale 1ns/10ps
module ptp_fan_model (
   input  wire logic clk,
   input  wire logic fan_on,
   input  wire logic stall,
   output logic      tach
);
   logic [1:0] ph;
   initial begin
      tach = 1'b0;
      ph = 2'b00;
   end
   // one tach edge every fourth cycle while powered and free
   always @(posedge clk) begin
      ph <= ph + 2'b01;
      if (fan_on && !stall && ph == 2'b11) tach <= !tach;
   end
endmodule

// >>> tb/ptp_top_tb.sv
// Purpose: scenario bench for the protection supervisor
// Assumes: housekeeping tick shortened to 10 cycles
// Notes:   inputs change on falling edges, except fan_tach from the fan model on rising edges
`timescale 1ns/10ps
module ptp_top_tb;
   logic        clk, sys_rst, seat_sw, fan_tach, mot_ot_sw, mfan_en, stall_en, stall;
   logic        xf_src_mot, fault_clr, mfan_out, hs_fan_out, brake_req, cutout;
   logic        gauge_warn, low_batt_prof, curr_cut_dis, curr_cut_chg;
   logic [11:0] hs_temp, mot_temp, hs_on_t, hs_off_t, xf_on_t, xf_off_t, mot_t_limit;
   logic [15:0] batt_v, mot_speed, speed_lim, trip_speed, ov_start, ov_cut, uv_start;
   logic [15:0] uv_cut, uv_delay_ms, reset_cell_v, chg_lim;
   logic [15:0] dis_lim [4];
   logic signed [15:0] mot_curr, batt_curr, dis_lim_act, chg_lim_act, batt_curr_rpt;
   logic [7:0]  xf_volt, out_busy, cells, xf_out, xf_level, brake_scale, drive_scale;
   logic [2:0]  xf_out_sel, ov_gain, uv_gain;
   logic [3:0]  est_gain;
   logic [23:0] est_limit;
   logic [9:0]  gauge_rate;
   logic [6:0]  warn_pct, cut_pct, gauge_pct;
   logic [4:0]  faults;
   logic [1:0]  profile;
   int          n_errors, tests_run, i;

   ptp_top #(.TICK_CYC(10)) ptp_top_inst (.*);
   ptp_fan_model ptp_fan_model_inst (.clk, .fan_on(hs_fan_out), .stall, .tach(fan_tach));

   // free-running 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = !clk;
   end

   task cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         $display("ERROR %s expected %h seen %h", nm, e, g);
         n_errors++;
      end
   endtask
   task tmo(input int k, input int n);
      if (k >= n) begin
         n_errors++;
         end_of_test();
      end
   endtask
   task end_of_test;
      if (n_errors == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task clr;
      fault_clr = 1'b1;
      cyc(4); // causes still in the pipe win for a few edges
      fault_clr = 1'b0;
      cyc(2);
   endtask

   task t_seat;
      mfan_en = 1'b1;
      cyc(5);
      chk("mfan off", 0, mfan_out);
      seat_sw = 1'b1;
      cyc(5);
      chk("mfan on", 1, mfan_out);
   endtask
   task t_hs;
      hs_temp = 12'h064;
      cyc(3);
      chk("hs at on", 0, hs_fan_out);
      hs_temp = 12'h065;
      cyc(3);
      chk("hs on", 1, hs_fan_out);
      hs_temp = 12'h033;
      cyc(3);
      chk("hs hold", 1, hs_fan_out);
      hs_temp = 12'h032;
      cyc(3);
      chk("hs off", 0, hs_fan_out);
   endtask
   task t_stall;
      stall_en = 1'b1;
      hs_temp = 12'h065;
      cyc(2000);
      chk("stall spin", 0, faults[0]);
      stall = 1'b1;
      for (i = 0; i < 12000 && faults[0] !== 1'b1; i++) cyc(1);
      tmo(i, 12000);
      chk("stall late", 1, i > 9000);
      hs_temp = 12'h000;
      stall = 1'b0;
      clr();
   endtask
   task t_xf;
      hs_temp = 12'h0ff;
      cyc(3);
      chk("xf source", 8'h00, xf_out);
      mot_temp = 12'h051;
      cyc(3);
      chk("xf on", 8'h08, xf_out);
      chk("xf level", 8'h80, xf_level);
      out_busy = 8'h08;
      cyc(3);
      chk("xf busy", 8'h00, xf_out);
      out_busy = 8'h00;
      cyc(3);
      mot_temp = 12'h029;
      cyc(3);
      chk("xf hold", 8'h08, xf_out);
      mot_temp = 12'h028;
      cyc(3);
      chk("xf off", 8'h00, xf_out);
      xf_src_mot = 1'b0;
      cyc(3);
      chk("xf hs src", 8'h08, xf_out);
      xf_src_mot = 1'b1;
      hs_temp = 12'h000;
   endtask
   task t_ot;
      mot_curr = 16'sh0100;
      for (i = 0; i < 500 && faults[1] !== 1'b1; i++) cyc(1);
      tmo(i, 500);
      chk("estimate", 1, faults[1]);
      mot_curr = 16'sh0000;
      sys_rst = 1'b1;
      cyc(3);
      sys_rst = 1'b0;
      cyc(4);
      chk("reset faults", 5'h00, faults);
      mot_ot_sw = 1'b1;
      cyc(5);
      chk("ot switch", 1, faults[1]);
      mot_ot_sw = 1'b0;
      clr();
   endtask
   task t_spd;
      mot_speed = 16'h1800;
      cyc(2);
      chk("brake", 1, brake_req);
      chk("no trip", 0, cutout);
      mot_speed = 16'h2001;
      cyc(2);
      chk("trip", 1, faults[2]);
      cyc(1);
      chk("brake off", 0, brake_req);
      mot_speed = 16'h0000;
      clr();
      chk("trip clr", 0, cutout);
   endtask
   task t_batt;
      batt_v = 16'h0bbc;
      cyc(2);
      chk("ov scale", 8'hf7, brake_scale);
      batt_v = 16'h0c1d;
      cyc(2);
      chk("ov cut", 2'b11, {faults[3], cutout});
      batt_v = 16'h03e6;
      clr();
      chk("uv scale", 8'hf7, drive_scale);
      batt_v = 16'h0383;
      cyc(25);
      chk("uv early", 0, faults[4]);
      for (i = 0; i < 100 && faults[4] !== 1'b1; i++) cyc(1);
      tmo(i, 100);
      chk("uv cut", 1, cutout);
      batt_v = 16'h07d0;
      clr();
   endtask
   task t_gauge;
      cyc(2);
      chk("gauge off", 7'h00, gauge_pct);
      cells = 8'h02;
      cyc(2);
      chk("gauge full", 7'h64, gauge_pct);
      batt_v = 16'h07cf;
      for (i = 0; i < 2500 && gauge_pct !== 7'h62; i++) cyc(1);
      tmo(i, 2500);
      chk("gauge rate", 1, i > 990);
      cyc(2);
      chk("low profile", 2'b11, {low_batt_prof, gauge_warn});
      warn_pct = 7'h00;
      cut_pct = 7'h00;
      cyc(2);
      chk("levels off", 2'b00, {low_batt_prof, gauge_warn});
      cells = 8'h00;
      batt_v = 16'h07d0;
   endtask
   task t_cur;
      batt_curr = 16'sh003c;
      cyc(2);
      chk("dis lim 2", 1, curr_cut_dis);
      profile = 2'h1;
      cyc(2);
      chk("dis lim 1", 0, curr_cut_dis);
      chk("dis act", 16'h00c8, dis_lim_act);
      batt_curr = -16'sd150;
      cyc(2);
      chk("chg lim", 1, curr_cut_chg);
      chk("regen", -16'sd150, batt_curr_rpt);
      chk("chg act", -16'sd100, chg_lim_act);
   endtask

   // main sequence
   initial begin
      n_errors = 0;
      tests_run = 0;
      sys_rst = 1'b1;
      {seat_sw, mot_ot_sw, mfan_en, stall_en, stall, fault_clr} = 6'h00;
      {hs_temp, mot_temp, mot_curr, batt_curr, mot_speed, out_busy} = '0;
      {hs_on_t, hs_off_t, xf_on_t, xf_off_t} = {12'h064, 12'h032, 12'h050, 12'h028};
      {xf_src_mot, xf_out_sel, xf_volt} = {1'b1, 3'h3, 8'h80};
      {est_gain, est_limit, mot_t_limit} = {4'h4, 24'h008000, 12'h800};
      {speed_lim, trip_speed, batt_v} = {16'h1000, 16'h2000, 16'h07d0};
      {ov_start, ov_cut, ov_gain} = {16'h0bb8, 16'h0c1c, 3'h1};
      {uv_start, uv_cut, uv_gain, uv_delay_ms} = {16'h03e8, 16'h0384, 3'h2, 16'h0003};
      {cells, reset_cell_v, gauge_rate} = {8'h00, 16'h03e8, 10'h001};
      {warn_pct, cut_pct, chg_lim, profile} = {7'h63, 7'h62, 16'h0064, 2'h2};
      dis_lim = '{16'h00c8, 16'h00c8, 16'h0032, 16'h00c8};
      cyc(16);
      sys_rst = 1'b0;
      cyc(2);
      t_seat();
      t_hs();
      t_stall();
      t_xf();
      t_ot();
      t_spd();
      t_batt();
      t_gauge();
      t_cur();
      end_of_test();
   end
endmodule
bind ptp_top ptp_top_assertions #(.VW(VW), .SW(SW), .IW(IW)) ptp_top_assertions_inst (
   .clk, .sys_rst, .seat_sw, .batt_v, .ov_cut, .mot_speed, .speed_lim, .cells, .chg_lim,
   .batt_curr, .fault_clr, .mfan_out, .xf_out, .xf_level, .brake_req, .cutout, .faults,
   .gauge_pct, .chg_lim_act, .batt_curr_rpt);
